//--- hdl/mpsd_pkg.sv
// Purpose: shared constants for the modem preamble, spacing and deviation registers
// Assumes: byte-wide register port, frequency words in units of crystal/2^18
// Notes: offsets are the register addresses of the host port
package mpsd_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [5:0] ADDR_PREAMBLE_SPACING_EXP = 6'h13;
  localparam logic [5:0] ADDR_SPACING_MANT = 6'h14;
  localparam logic [5:0] ADDR_DEVIATION = 6'h15;
  localparam int ADDR_W = 6;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int PRE_SEL_LSB = 4;
  localparam int DEV_EXP_LSB = 4;
  localparam int EXP_BIT7 = 7;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [2:0] PRE_SEL_RST = 3'h2;
  localparam logic RSV7_RST = 1'h0;
  localparam logic [1:0] CHANNEL_INDEX_STEP_EXP_RST = 2'h2;
  localparam logic [7:0] CHANNEL_INDEX_STEP_MANT_RST = 8'hf8;
  localparam logic [2:0] DEV_EXP_RST = 3'h4;
  localparam logic [2:0] DEV_MANT_RST = 3'h7;

  // ****************************************************************
  // formula offsets
  // ****************************************************************
  localparam logic [8:0] CHANNEL_INDEX_STEP_BASE = 9'h100;
  localparam logic [3:0] DEV_IMPLIED_ONE = 4'h8;

  // ****************************************************************
  // modulation formats
  // ****************************************************************
  typedef enum logic [2:0] {
    MOD_2FSK = 3'b000,
    MOD_GFSK = 3'b001,
    MOD_OOK = 3'b011,
    MOD_4FSK = 3'b100
  } mpsd_mod_t;
endpackage : mpsd_pkg

//--- hdl/mpsd_cfg_if.sv
// Purpose: carries decoded modem settings from register bank to frequency math
// Assumes: single clock domain
// Notes: fields are raw register contents, except devUsed, which is decoded from the modulation format
`timescale 1ns/100ps
`default_nettype none
interface mpsd_cfg_if;
  logic [1:0] chanStepExp;
  logic [7:0] chanStepMant;
  logic [2:0] devExp;
  logic [2:0] devMant;
  logic devUsed;
  modport bank (output chanStepExp, output chanStepMant, output devExp, output devMant,
    output devUsed);
  modport calc (input chanStepExp, input chanStepMant, input devExp, input devMant,
    input devUsed);
endinterface : mpsd_cfg_if
`default_nettype wire

//--- hdl/mpsd_freq_calc.sv
// Purpose: channel spacing, carrier and deviation arithmetic
// Assumes: frequency words in units of crystal/2^18
// Notes: purely combinational, results registered by the caller
`timescale 1ns/100ps
`default_nettype none
module mpsd_freq_calc #(
  parameter int FREQ_W = 32
) (
  mpsd_cfg_if.calc cfg,
  input wire logic [7:0] channelIndex,
  input wire logic [FREQ_W-1:0] baseFreq,
  output logic [11:0] chanStep,
  output logic [11:0] devWord,
  output logic [FREQ_W-1:0] carrierFreq
);
  logic [8:0] stepMant;
  logic [3:0] devMant4;
  logic [19:0] chanOffset;

  // ****************************************************************
  // spacing: (256 + mant) << exp, in crystal/2^18 units
  // ****************************************************************
  always_comb begin
    stepMant = mpsd_pkg::CHANNEL_INDEX_STEP_BASE | {1'b0, cfg.chanStepMant};
    // widen before shifting so the top exponent keeps every mantissa bit
    chanStep = 12'(stepMant) << cfg.chanStepExp;
    chanOffset = 20'(chanStep) * 20'(channelIndex);
    carrierFreq = baseFreq + FREQ_W'(chanOffset);
  end

  // ****************************************************************
  // deviation: (8 + mant) << exp over 2^17, doubled to 2^18 units
  // ****************************************************************
  always_comb begin
    devMant4 = mpsd_pkg::DEV_IMPLIED_ONE | {1'b0, cfg.devMant};
    // ook zeroes the deviation so neither direction sees it
    if (cfg.devUsed) begin
      devWord = 12'({devMant4, 1'b0}) << cfg.devExp;
    end else begin
      devWord = 12'h000;
    end
  end
endmodule : mpsd_freq_calc
`default_nettype wire

//--- hdl/mpsd_modem_cfg.sv
// Purpose: preamble length, channel spacing and deviation register bank
// Assumes: register port already decoded from the serial host port, one access a cycle
// Notes: frequency outputs registered one cycle after their inputs change
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// - preamble minimum from 3-bit code: 2,3,4,6,8,12,16,24 bytes; reset code 2
// - spacing = xtal/2^18 * (256 + mantissa) * 2^exponent
// - carrier = base frequency + spacing * channel index
// - spacing mantissa resets to 248, exponent to 2
// - deviation = xtal/2^17 * (8 + 3-bit mantissa) * 2^exponent
// - fsk transmit: zero symbol below carrier, one symbol above by deviation
// - ook ignores deviation fields for receive and transmit
// - deviation exponent resets to 4, mantissa to 7
// - format code 0 2-fsk, 1 gfsk, 3 ook, 4 4-fsk, others reserved
module mpsd_modem_cfg #(
  parameter int FREQ_W = 32
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [mpsd_pkg::ADDR_W-1:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output logic regHit,
  input wire logic [2:0] modulationSelect,
  input wire logic [7:0] channelIndex,
  input wire logic [FREQ_W-1:0] baseFreq,
  input wire logic txActive,
  input wire logic txSymbol,
  output logic [4:0] preambleMinBytes,
  output logic [11:0] chanStepWord,
  output logic [11:0] rxDeviationWord,
  output logic [FREQ_W-1:0] carrierFreq,
  output logic [FREQ_W-1:0] txFreq,
  output logic modReserved
);
  // ****************************************************************
  // register state
  // ****************************************************************
  logic [2:0] preSel_reg, preSel_next;
  logic rsv7_reg, rsv7_next;
  logic [1:0] chanStepExp_reg, chanStepExp_next;
  logic [7:0] chanStepMant_reg, chanStepMant_next;
  logic [2:0] devExp_reg, devExp_next;
  logic [2:0] devMant_reg, devMant_next;
  logic [4:0] preBytes_reg, preBytes_next;
  logic [11:0] step_reg, step_next;
  logic [11:0] rxDev_reg, rxDev_next;
  logic [FREQ_W-1:0] carrier_reg, carrier_next;
  logic [FREQ_W-1:0] txFreq_reg, txFreq_next;
  logic reserved_reg, reserved_next;
  logic [11:0] calcStep;
  logic [11:0] calcDev;
  logic [FREQ_W-1:0] calcCarrier;
  mpsd_cfg_if cfgBus();

  // ****************************************************************
  // helpers
  // ****************************************************************
  // preamble code to byte count, table kept in logic to avoid a rom
  function automatic logic [4:0] preamble_bytes(input logic [2:0] code);
    case (code)
      3'h0: preamble_bytes = 5'h02;
      3'h1: preamble_bytes = 5'h03;
      3'h2: preamble_bytes = 5'h04;
      3'h3: preamble_bytes = 5'h06;
      3'h4: preamble_bytes = 5'h08;
      3'h5: preamble_bytes = 5'h0c;
      3'h6: preamble_bytes = 5'h10;
      default: preamble_bytes = 5'h18;
    endcase
  endfunction : preamble_bytes

  // true for the formats that shift the carrier by the deviation
  function automatic logic is_fsk(input logic [2:0] fmt);
    case (fmt)
      mpsd_pkg::MOD_2FSK, mpsd_pkg::MOD_GFSK, mpsd_pkg::MOD_4FSK: is_fsk = 1'b1;
      default: is_fsk = 1'b0;
    endcase
  endfunction : is_fsk

  // ****************************************************************
  // register writes
  // ****************************************************************
  // unused bits are simply never stored, except reserved bit 7 at 0x13, so writes to the others vanish
  always_comb begin
    preSel_next = preSel_reg;
    rsv7_next = rsv7_reg;
    chanStepExp_next = chanStepExp_reg;
    chanStepMant_next = chanStepMant_reg;
    devExp_next = devExp_reg;
    devMant_next = devMant_reg;
    if (regWrEn) begin
      case (regAddr)
        mpsd_pkg::ADDR_PREAMBLE_SPACING_EXP: begin
          rsv7_next = regWrData[mpsd_pkg::EXP_BIT7];
          preSel_next = regWrData[mpsd_pkg::PRE_SEL_LSB +: 3];
          chanStepExp_next = regWrData[1:0];
        end
        mpsd_pkg::ADDR_SPACING_MANT: begin
          chanStepMant_next = regWrData;
        end
        mpsd_pkg::ADDR_DEVIATION: begin
          devExp_next = regWrData[mpsd_pkg::DEV_EXP_LSB +: 3];
          devMant_next = regWrData[2:0];
        end
        default: begin
          preSel_next = preSel_reg;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      preSel_reg <= mpsd_pkg::PRE_SEL_RST;
      rsv7_reg <= mpsd_pkg::RSV7_RST;
      chanStepExp_reg <= mpsd_pkg::CHANNEL_INDEX_STEP_EXP_RST;
      chanStepMant_reg <= mpsd_pkg::CHANNEL_INDEX_STEP_MANT_RST;
      devExp_reg <= mpsd_pkg::DEV_EXP_RST;
      devMant_reg <= mpsd_pkg::DEV_MANT_RST;
    end else begin
      preSel_reg <= preSel_next;
      rsv7_reg <= rsv7_next;
      chanStepExp_reg <= chanStepExp_next;
      chanStepMant_reg <= chanStepMant_next;
      devExp_reg <= devExp_next;
      devMant_reg <= devMant_next;
    end
  end

  // ****************************************************************
  // register reads
  // ****************************************************************
  // combinational read, unmapped addresses return zero with regHit low
  always_comb begin
    regRdData = 8'h00;
    regHit = 1'b1;
    case (regAddr)
      mpsd_pkg::ADDR_PREAMBLE_SPACING_EXP: begin
        regRdData = {rsv7_reg, preSel_reg, 2'b00, chanStepExp_reg};
      end
      mpsd_pkg::ADDR_SPACING_MANT: begin
        regRdData = chanStepMant_reg;
      end
      mpsd_pkg::ADDR_DEVIATION: begin
        regRdData = {1'b0, devExp_reg, 1'b0, devMant_reg};
      end
      default: begin
        regHit = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // frequency arithmetic
  // ****************************************************************
  assign cfgBus.chanStepExp = chanStepExp_reg;
  assign cfgBus.chanStepMant = chanStepMant_reg;
  assign cfgBus.devExp = devExp_reg;
  assign cfgBus.devMant = devMant_reg;
  assign cfgBus.devUsed = is_fsk(modulationSelect);

  mpsd_freq_calc #(
    .FREQ_W(FREQ_W)
  ) u_calc (
    .cfg(cfgBus),
    .channelIndex(channelIndex),
    .baseFreq(baseFreq),
    .chanStep(calcStep),
    .devWord(calcDev),
    .carrierFreq(calcCarrier)
  );

  // ****************************************************************
  // output staging
  // ****************************************************************
  // one register stage cuts the multiplier path before the synthesizer
  always_comb begin
    preBytes_next = preamble_bytes(preSel_reg);
    step_next = calcStep;
    rxDev_next = calcDev;
    carrier_next = calcCarrier;
    reserved_next = ~is_fsk(modulationSelect) && (modulationSelect != mpsd_pkg::MOD_OOK);
    txFreq_next = calcCarrier;
    if (txActive) begin
      // 4-fsk outer symbols are left to the modulator, only the sign is applied here
      if (txSymbol) begin
        txFreq_next = calcCarrier + FREQ_W'(calcDev);
      end else begin
        txFreq_next = calcCarrier - FREQ_W'(calcDev);
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      preBytes_reg <= 5'h00;
      step_reg <= 12'h000;
      rxDev_reg <= 12'h000;
      carrier_reg <= '0;
      txFreq_reg <= '0;
      reserved_reg <= 1'b0;
    end else begin
      preBytes_reg <= preBytes_next;
      step_reg <= step_next;
      rxDev_reg <= rxDev_next;
      carrier_reg <= carrier_next;
      txFreq_reg <= txFreq_next;
      reserved_reg <= reserved_next;
    end
  end

  assign preambleMinBytes = preBytes_reg;
  assign chanStepWord = step_reg;
  assign rxDeviationWord = rxDev_reg;
  assign carrierFreq = carrier_reg;
  assign txFreq = txFreq_reg;
  assign modReserved = reserved_reg; // flags a reserved format code
endmodule : mpsd_modem_cfg
`default_nettype wire

//--- tb/mpsd_modem_cfg_sva.sv
// Purpose: port checks for the modem preamble, spacing and deviation bank
// Assumes: shadow copies of the three registers follow host writes
// Notes: frequency outputs lag their causes by one clock
`timescale 1ns/100ps
`default_nettype none
module mpsd_modem_cfg_sva #(
  parameter int FREQ_W = 32
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [mpsd_pkg::ADDR_W-1:0] regAddr,
  input wire logic regWrEn,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic regHit,
  input wire logic [2:0] modulationSelect,
  input wire logic [7:0] channelIndex,
  input wire logic [FREQ_W-1:0] baseFreq,
  input wire logic txActive,
  input wire logic txSymbol,
  input wire logic [4:0] preambleMinBytes,
  input wire logic [11:0] chanStepWord,
  input wire logic [11:0] rxDeviationWord,
  input wire logic [FREQ_W-1:0] carrierFreq,
  input wire logic [FREQ_W-1:0] txFreq,
  input wire logic modReserved
);
  logic [7:0] cfg13_reg, cfg14_reg, cfg15_reg, cfg13_next, cfg14_next, cfg15_next;
  logic [4:0] preTab [8] = '{5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0c, 5'h10, 5'h18};
  function automatic logic fskSel(input logic [2:0] m);
    return m == 3'h0 || m == 3'h1 || m == 3'h4;
  endfunction : fskSel
  // ****************************************************************
  // shadow registers
  // ****************************************************************
  // unused bits masked so read-back compares stay exact
  always_comb begin
    cfg13_next = cfg13_reg;
    cfg14_next = cfg14_reg;
    cfg15_next = cfg15_reg;
    if (regWrEn && regAddr == 6'h13) cfg13_next = regWrData & 8'hf3;
    if (regWrEn && regAddr == 6'h14) cfg14_next = regWrData;
    if (regWrEn && regAddr == 6'h15) cfg15_next = regWrData & 8'h77;
  end
  // reset values match the register table
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg13_reg <= 8'h22;
      cfg14_reg <= 8'hf8;
      cfg15_reg <= 8'h47;
    end else begin
      cfg13_reg <= cfg13_next;
      cfg14_reg <= cfg14_next;
      cfg15_reg <= cfg15_next;
    end
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_wr14;
    regWrEn && regAddr == 6'h14;
  endsequence
  sequence s_run;
    $past(rstn);
  endsequence
  property p_hit;
    regHit == (regAddr >= 6'h13 && regAddr <= 6'h15);
  endproperty
  property p_rdback;
    regHit |-> regRdData == (regAddr == 6'h13 ? cfg13_reg :
      regAddr == 6'h14 ? cfg14_reg : cfg15_reg);
  endproperty
  property p_unused;
    regAddr == 6'h15 |-> !regRdData[7] && !regRdData[3];
  endproperty
  property p_wrnext;
    s_wr14 ##1 regAddr == 6'h14 |-> regRdData == $past(regWrData);
  endproperty
  property p_pre;
    s_run |-> preambleMinBytes == preTab[$past(cfg13_reg[6:4])];
  endproperty
  property p_step;
    s_run |-> chanStepWord == (12'(9'h100 + $past(cfg14_reg)) << $past(cfg13_reg[1:0]));
  endproperty
  property p_carrier;
    s_run |-> carrierFreq == $past(baseFreq) + FREQ_W'(chanStepWord) *
      FREQ_W'($past(channelIndex));
  endproperty
  property p_dev;
    s_run ##0 fskSel($past(modulationSelect)) |-> rxDeviationWord ==
      ((12'(4'h8 + $past(cfg15_reg[2:0])) << $past(cfg15_reg[6:4])) << 1);
  endproperty
  property p_ook;
    s_run ##0 !fskSel($past(modulationSelect)) |-> rxDeviationWord == 12'h0 ##0
      txFreq == carrierFreq;
  endproperty
  property p_tx;
    s_run |-> txFreq == (!$past(txActive) ? carrierFreq : $past(txSymbol) ?
      carrierFreq + FREQ_W'(rxDeviationWord) : carrierFreq - FREQ_W'(rxDeviationWord));
  endproperty
  property p_rsv;
    s_run |-> modReserved == !(fskSel($past(modulationSelect)) ||
      $past(modulationSelect) == 3'h3);
  endproperty
  a_hit: assert property (p_hit) else $error("register hit wrong");
  a_rdback: assert property (p_rdback) else $error("read-back wrong");
  a_unused: assert property (p_unused) else $error("unused bit set");
  a_wrnext: assert property (p_wrnext) else $error("write not seen");
  a_pre: assert property (p_pre) else $error("preamble length wrong");
  a_step: assert property (p_step) else $error("spacing wrong");
  a_carrier: assert property (p_carrier) else $error("carrier wrong");
  a_dev: assert property (p_dev) else $error("deviation wrong");
  a_ook: assert property (p_ook) else $error("deviation not ignored");
  a_tx: assert property (p_tx) else $error("tx shift wrong");
  a_rsv: assert property (p_rsv) else $error("reserved flag wrong");
endmodule : mpsd_modem_cfg_sva
bind mpsd_modem_cfg mpsd_modem_cfg_sva #(.FREQ_W(FREQ_W)) u_sva (.clk, .rstn, .regAddr,
  .regWrEn, .regWrData, .regRdData, .regHit, .modulationSelect, .channelIndex, .baseFreq,
  .txActive, .txSymbol, .preambleMinBytes, .chanStepWord, .rxDeviationWord, .carrierFreq,
  .txFreq, .modReserved);
`default_nettype wire

//--- tb/test_mpsd_modem_cfg.sv
// Purpose: register and frequency checks of the modem config bank
// Assumes: inputs change at the falling edge
// Notes: expected values come from the field formulas
`timescale 1ns/100ps
`default_nettype none
module test_mpsd_modem_cfg;
  logic clk = 1'b0, rstn = 1'b0, regWrEn = 1'b0, txActive = 1'b0, txSymbol = 1'b0;
  logic [5:0] regAddr = 6'h0;
  logic [7:0] regWrData = 8'h0, channelIndex = 8'hff, regRdData;
  logic [2:0] modulationSelect = 3'h0;
  logic [31:0] baseFreq = 32'h00100000, carrierFreq, txFreq, stp, dev, car;
  logic [11:0] chanStepWord, rxDeviationWord;
  logic [4:0] preambleMinBytes;
  logic regHit, modReserved, fsk;
  logic [4:0] preTab [8] = '{5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0c, 5'h10, 5'h18};
  int fails = 0;
  int checks = 0;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  mpsd_modem_cfg #(.FREQ_W(32)) DUT (.clk, .rstn, .regAddr, .regWrEn, .regWrData,
    .regRdData, .regHit, .modulationSelect, .channelIndex, .baseFreq, .txActive, .txSymbol,
    .preambleMinBytes, .chanStepWord, .rxDeviationWord, .carrierFreq, .txFreq, .modReserved);
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task stop_test;
    if (fails == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  // one write strobe per call, dropped a cycle later
  task wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge clk);
    regWrEn = 1'b0;
  endtask : wr
  task rd(input logic [5:0] a, input logic [7:0] e);
    @(negedge clk);
    regAddr = a;
    #1 chk(regRdData, e);
  endtask : rd
  // registered outputs need two edges; three gives margin
  task settle;
    repeat (3) @(negedge clk);
  endtask : settle
  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    rd(6'h13, 8'h22);
    rd(6'h14, 8'hf8);
    rd(6'h15, 8'h47);
    settle;
    chk(preambleMinBytes, 32'h4);
    chk(chanStepWord, 32'h7e0);
    chk(rxDeviationWord, 32'h1e0);
    wr(6'h16, 8'h00);
    rd(6'h14, 8'hf8);
    rd(6'h16, 8'h00);
    chk(regHit, 32'h0);
    wr(6'h13, 8'hff);
    rd(6'h13, 8'hf3);
    wr(6'h15, 8'hff);
    rd(6'h15, 8'h77);
    for (int c = 0; c < 8; c++) begin
      wr(6'h13, {1'b0, 3'(c), 4'h0});
      settle;
      chk(preambleMinBytes, preTab[c]);
    end
    // mantissa corners at every exponent, carrier from top channel
    for (int k = 0; k < 8; k++) begin
      wr(6'h13, {6'h0, 2'(k >> 1)});
      wr(6'h14, (k & 1) ? 8'hff : 8'h00);
      settle;
      stp = ((k & 1) ? 32'h1ff : 32'h100) << (k >> 1);
      chk(chanStepWord, stp);
      chk(carrierFreq, baseFreq + stp * 32'hff);
    end
    // carrier expected from the last spacing setting, not from the design
    car = baseFreq + stp * 32'hff;
    txActive = 1'b1;
    for (int e = 0; e < 8; e++) begin
      wr(6'h15, {1'b0, 3'(e), 1'b0, 3'(e)});
      txSymbol = 1'b1;
      settle;
      dev = ((32'h8 + e) << e) << 1;
      chk(rxDeviationWord, dev);
      chk(txFreq, car + dev);
      txSymbol = 1'b0;
      settle;
      chk(txFreq, car - dev);
    end
    for (int c = 0; c < 8; c++) begin
      modulationSelect = 3'(c);
      settle;
      fsk = (c == 0 || c == 1 || c == 4);
      chk(modReserved, !(fsk || c == 3));
      chk(rxDeviationWord, fsk ? dev : 32'h0);
      chk(txFreq, car - (fsk ? dev : 32'h0));
    end
    // mid-run reset must bring back every default, not only at power-up
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    rd(6'h13, 8'h22);
    rd(6'h14, 8'hf8);
    rd(6'h15, 8'h47);
    settle;
    chk(preambleMinBytes, 32'h4);
    chk(chanStepWord, 32'h7e0);
    stop_test;
  end
  // watchdog well past the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    stop_test;
  end
endmodule : test_mpsd_modem_cfg
`default_nettype wire
